// File: logic/vlan_egress_filter.sv
// port-based vlan egress filter with apb configuration
// assumes frame lookups arrive synchronous to clk_sys
//
// Notes on behaviour
// - forwarding follows destination mac's port, given by the lookup input.
// - per ingress port an egress set; forward only inside it.
// - vlan id fixed at 1 in port-based mode, not writable.
// - management port in every port's ingress and egress sets by default.
// - all-connected preset sets every pair, management included.
// - isolation preset: every ingress enabled, only management egress for ethernet ports.
// - per-port edits after a preset take effect only on apply.
// - no management delivery when a port's set excludes management.
// - membership is local; nothing is signalled to other switches.
// - applied matrix is volatile; save copies it to a saved image.
`default_nettype none
module vlan_egress_filter
    import vlan_filter_pkg::*;
#(
    parameter int NPORT = 8 // ethernet ports; index NPORT is management
)(
    input  wire logic               clk_sys,
    input  wire logic               srst,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic [31:0]             prdata,
    output logic                    pslverr,
    input  wire logic               lookup_valid,
    input  wire logic [7:0]         lookup_ingress,
    input  wire logic [NPORT:0]     lookup_dest,
    output logic                    fwd_valid,
    output logic [NPORT:0]          fwd_mask,
    output logic [11:0]             fwd_vid,
    output logic                    pbv_active
);
    localparam int NP = NPORT + 1;
    localparam logic [NPORT:0] ALL_ONES = {NP{1'b1}};
    localparam logic [NPORT:0] MGMT_ONLY = {1'b1, {NPORT{1'b0}}};
    // reset image: every port reaches management, management reaches all
    // ports, so the switch stays manageable from any port after reset
    localparam logic [NP*NP-1:0] LIVE_RESET = {ALL_ONES, {NPORT{MGMT_ONLY}}};

    typedef struct packed
    {
        logic [NP*NP-1:0]   live;     // egress bit [ing*NP+egr]
        logic [NP*NP-1:0]   shadow;
        logic [NP*NP-1:0]   saved;
        logic [NPORT:0]     ing_live;
        logic [NPORT:0]     ing_shadow;
        logic [7:0]         rowsel;
        logic               pbv_en;
        apply_state_t       state;
        logic               pready;
        logic [31:0]        prdata;
        logic               pslverr;
        logic               fwd_valid;
        logic [NPORT:0]     fwd_mask;
        logic [11:0]        fwd_vid;
        logic               pbv_active;
        logic [7:0]         apply_count;
    } state_t;

    state_t cur;
    state_t next_cur;

    function automatic logic [NP*NP-1:0] fill_matrix(input logic [NPORT:0] r);
        logic [NP*NP-1:0] m;
        m = '0;
        for (int i = 0; i < NP; i++)
        begin
            m[i*NP +: NP] = r;
        end
        return m;
    endfunction

    // one list of mapped offsets, shared by the write error decode and the checks
    function automatic logic addr_known(input logic [7:0] a);
        logic k;
        case (a)
            OFS_CTRL, OFS_STATUS, OFS_ROWSEL, OFS_INGRESS,
            OFS_EGRESS, OFS_VID, OFS_SAVED: k = 1'b1;
            default: k = 1'b0;
        endcase
        return k;
    endfunction

    // ******************************
    // configuration, apply and lookup
    // ******************************
    logic        acc;
    logic        wr;
    logic [7:0]  row;

    always_comb
    begin
        next_cur = cur;
        acc = psel && penable && !cur.pready;
        wr = psel && penable && pwrite && cur.pready;
        row = cur.rowsel;
        next_cur.pready = acc;
        next_cur.pslverr = 1'b0;
        next_cur.state = ST_IDLE;
        if (acc && !pwrite)
        begin
            next_cur.prdata = 32'h0;
            case (paddr)
                OFS_CTRL:    next_cur.prdata[CTRL_PBV_EN] = cur.pbv_en;
                OFS_STATUS:  next_cur.prdata = {24'h0, cur.apply_count};
                OFS_ROWSEL:  next_cur.prdata = {24'h0, cur.rowsel};
                OFS_INGRESS: next_cur.prdata[NPORT:0] = cur.ing_shadow;
                OFS_EGRESS:
                begin
                    if (row < 8'(NP))
                        next_cur.prdata[NPORT:0] =
                            cur.shadow[row*NP +: NP];
                end
                OFS_VID:     next_cur.prdata[11:0] = FIXED_VID;
                OFS_SAVED:
                begin
                    if (row < 8'(NP))
                        next_cur.prdata[NPORT:0] =
                            cur.saved[row*NP +: NP];
                end
                default:     next_cur.pslverr = 1'b1;
            endcase
        end
        // errors are decided in the access cycle so they stand with
        // pready; the write itself lands on the edge that sees pready
        if (acc && pwrite)
        begin
            if (!addr_known(paddr))
                next_cur.pslverr = 1'b1;
            else if (paddr == OFS_EGRESS && !(row < 8'(NP)))
                next_cur.pslverr = 1'b1;
        end
        if (wr)
        begin
            case (paddr)
                OFS_CTRL:
                begin
                    next_cur.pbv_en = pwdata[CTRL_PBV_EN];
                    // presets load the shadow; they need apply too
                    case (pwdata[CTRL_PRESET_LO +: 2])
                        PRESET_ALL:
                        begin
                            next_cur.shadow = fill_matrix(ALL_ONES);
                            next_cur.ing_shadow = ALL_ONES;
                        end
                        PRESET_ISOLATE:
                        begin
                            next_cur.shadow = fill_matrix(MGMT_ONLY);
                            // management itself still reaches every port
                            next_cur.shadow[NPORT*NP +: NP] = ALL_ONES;
                            next_cur.ing_shadow = ALL_ONES;
                        end
                        default:
                        begin
                        end
                    endcase
                    if (pwdata[CTRL_APPLY])
                        next_cur.state = ST_APPLY;
                    if (pwdata[CTRL_SAVE])
                        next_cur.saved = cur.live;
                end
                OFS_ROWSEL: next_cur.rowsel = pwdata[7:0];
                OFS_INGRESS: next_cur.ing_shadow = pwdata[NPORT:0];
                OFS_EGRESS:
                begin
                    if (row < 8'(NP))
                        next_cur.shadow[row*NP +: NP] = pwdata[NPORT:0];
                end
                OFS_STATUS, OFS_VID, OFS_SAVED:
                begin
                end
                default:
                begin
                end
            endcase
        end
        // whole matrix swapped in one edge
        if (cur.state == ST_APPLY)
        begin
            next_cur.live = cur.shadow;
            next_cur.ing_live = cur.ing_shadow;
            next_cur.apply_count = cur.apply_count + 8'h01;
        end
        // lookup: dest port set comes from the mac table outside
        next_cur.fwd_valid = lookup_valid;
        next_cur.fwd_mask = '0;
        if (lookup_valid && lookup_ingress < 8'(NP))
        begin
            if (!cur.pbv_en)
                next_cur.fwd_mask = lookup_dest;
            else if (cur.ing_live[lookup_ingress[$clog2(NP)-1:0]])
                next_cur.fwd_mask = lookup_dest &
                    cur.live[lookup_ingress*NP +: NP];
        end
        next_cur.fwd_vid = FIXED_VID;
        next_cur.pbv_active = cur.pbv_en;
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            cur <= '0;
            cur.live <= LIVE_RESET;
            cur.shadow <= LIVE_RESET;
            cur.ing_live <= ALL_ONES;
            cur.ing_shadow <= ALL_ONES;
            cur.pbv_en <= PBV_EN_RESET;
            cur.state <= ST_IDLE;
            cur.fwd_vid <= FIXED_VID;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign pready     = cur.pready;
    assign prdata     = cur.prdata;
    assign pslverr    = cur.pslverr;
    assign fwd_valid  = cur.fwd_valid;
    assign fwd_mask   = cur.fwd_mask;
    assign fwd_vid    = cur.fwd_vid;
    assign pbv_active = cur.pbv_active;

    // ******************************
    // checks
    // ******************************
    a_vid_fixed: assert property (@(posedge clk_sys) disable iff (srst)
        fwd_vid == FIXED_VID)
        else $error("vlan id not 1");
    a_fwd_subset: assert property (@(posedge clk_sys) disable iff (srst)
        (lookup_valid && cur.pbv_en && lookup_ingress < 8'(NP)) |=>
        ((fwd_mask & ~$past(cur.live[lookup_ingress*NP +: NP])) == '0))
        else $error("forward outside egress set");
    a_mgmt_block: assert property (@(posedge clk_sys) disable iff (srst)
        (lookup_valid && cur.pbv_en && lookup_ingress < 8'(NP) &&
         !cur.live[lookup_ingress*NP + NPORT]) |=> !fwd_mask[NPORT])
        else $error("management reached through excluded port");
    a_apply_only: assert property (@(posedge clk_sys) disable iff (srst)
        (cur.state != ST_APPLY) |=> $stable(cur.live))
        else $error("live matrix changed without apply");
    a_apply_whole: assert property (@(posedge clk_sys) disable iff (srst)
        (cur.state == ST_APPLY) |=> (cur.live == $past(cur.shadow)))
        else $error("apply not whole");
    a_all_preset: assert property (@(posedge clk_sys) disable iff (srst)
        (wr && paddr == OFS_CTRL &&
         pwdata[CTRL_PRESET_LO +: 2] == PRESET_ALL) |=>
        (cur.shadow == fill_matrix(ALL_ONES)))
        else $error("all-connected preset wrong");
    a_iso_preset: assert property (@(posedge clk_sys) disable iff (srst)
        (wr && paddr == OFS_CTRL &&
         pwdata[CTRL_PRESET_LO +: 2] == PRESET_ISOLATE) |=>
        (cur.shadow[NP-1:0] == MGMT_ONLY && cur.ing_shadow == ALL_ONES))
        else $error("isolation preset wrong");
    a_save_copy: assert property (@(posedge clk_sys) disable iff (srst)
        (wr && paddr == OFS_CTRL && pwdata[CTRL_SAVE]) |=>
        (cur.saved == $past(cur.live)))
        else $error("save did not copy live matrix");
    a_lookup_lat: assert property (@(posedge clk_sys) disable iff (srst)
        lookup_valid |=> fwd_valid)
        else $error("lookup answer late");
    // not gated by srst: it checks the cycle right after a reset edge
    a_reset_mat: assert property (@(posedge clk_sys)
        srst |=> (cur.live == LIVE_RESET && cur.ing_live == ALL_ONES))
        else $error("reset matrix wrong");
    a_ing_block: assert property (@(posedge clk_sys) disable iff (srst)
        (lookup_valid && cur.pbv_en && lookup_ingress < 8'(NP) &&
         !cur.ing_live[lookup_ingress[$clog2(NP)-1:0]]) |=>
        (fwd_mask == '0))
        else $error("frame from disabled ingress forwarded");
    a_off_pass: assert property (@(posedge clk_sys) disable iff (srst)
        (lookup_valid && !cur.pbv_en && lookup_ingress < 8'(NP)) |=>
        (fwd_mask == $past(lookup_dest)))
        else $error("disabled mode did not pass destination set");
    a_err_ready: assert property (@(posedge clk_sys) disable iff (srst)
        pslverr |-> pready)
        else $error("error flag without ready");
    a_rdy_pulse: assert property (@(posedge clk_sys) disable iff (srst)
        pready |=> !pready)
        else $error("ready held too long");
    a_err_map: assert property (@(posedge clk_sys) disable iff (srst)
        (acc && !addr_known(paddr)) |=> pslverr)
        else $error("unmapped offset not refused");
    a_vid_read: assert property (@(posedge clk_sys) disable iff (srst)
        (acc && !pwrite && paddr == OFS_VID) |=>
        (prdata[11:0] == FIXED_VID))
        else $error("vlan id read not 1");
    // a write must not land before the master has seen pready
    a_write_late: assert property (@(posedge clk_sys) disable iff (srst)
        acc |=> ($stable(cur.shadow) && $stable(cur.rowsel)))
        else $error("write landed in the access cycle");
    a_save_keep: assert property (@(posedge clk_sys) disable iff (srst)
        !(wr && paddr == OFS_CTRL && pwdata[CTRL_SAVE]) |=>
        $stable(cur.saved))
        else $error("saved image changed without save");
endmodule
`default_nettype wire

// File: logic/vlan_filter_pkg.sv
// constants for the port-based vlan egress filter
// assumes one switch clock and an apb master for software
`default_nettype none
package vlan_filter_pkg;
    // ******************************
    // register offsets (byte addresses)
    // ******************************
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_ROWSEL  = 8'h08;
    localparam logic [7:0] OFS_INGRESS = 8'h0c;
    localparam logic [7:0] OFS_EGRESS  = 8'h10;
    localparam logic [7:0] OFS_VID     = 8'h14;
    localparam logic [7:0] OFS_SAVED   = 8'h18;
    // ******************************
    // control fields
    // ******************************
    localparam int CTRL_PBV_EN    = 0;
    localparam int CTRL_APPLY     = 1;
    localparam int CTRL_PRESET_LO = 2;
    localparam int CTRL_SAVE      = 4;
    localparam logic [1:0] PRESET_NONE    = 2'h0;
    localparam logic [1:0] PRESET_ALL     = 2'h1;
    localparam logic [1:0] PRESET_ISOLATE = 2'h2;
    localparam logic [11:0] FIXED_VID     = 12'h001;
    localparam logic       PBV_EN_RESET   = 1'b1;
    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b00,
        ST_APPLY = 2'b01
    } apply_state_t;
endpackage
`default_nettype wire

// File: tb/port_side_model.sv
// far side model: ethernet port logic issuing frame lookups
// assumes send is called just after a rising clk_sys edge
`default_nettype none
module port_side_model #(
    parameter int NP = 8
)(
    input  wire logic   clk_sys,
    output logic        lookup_valid,
    output logic [7:0]  lookup_ingress,
    output logic [NP:0] lookup_dest
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        lookup_valid   = 1'b0;
        lookup_ingress = 8'h00;
        lookup_dest    = '0;
    end
    task automatic send(input logic [7:0] ing, input logic [NP:0] dst);
        lookup_valid   <= 1'b1;
        lookup_ingress <= ing;
        lookup_dest    <= dst;
        @(posedge clk_sys);
        lookup_valid   <= 1'b0;
        // released lines show junk so stale values cannot pass
        lookup_ingress <= ~ing;
        lookup_dest    <= ~dst;
    endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// bench for the port-based vlan egress filter
// assumes the filter and the port model; apb master lives here
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
    n_fail++; $display("Error %0t: got %h want %h", $time, g, e); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import vlan_filter_pkg::*;
    localparam int NP = 8;
    logic        clk_sys, srst, psel, penable, pwrite, pready, pslverr;
    logic        lookup_valid, fwd_valid, pbv_active, er;
    logic [7:0]  paddr, lookup_ingress, s;
    logic [31:0] pwdata, prdata, rv;
    logic [NP:0] lookup_dest, fwd_mask, fm;
    logic [11:0] fwd_vid;
    int          n_fail = 0;
    int          total_checks = 0;
    vlan_egress_filter #(.NPORT(NP)) vlan_egress_filter_inst (.clk_sys,
        .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr, .lookup_valid, .lookup_ingress, .lookup_dest, .fwd_valid,
        .fwd_mask, .fwd_vid, .pbv_active);
    port_side_model #(.NP(NP)) port_side_model_inst (.clk_sys,
        .lookup_valid, .lookup_ingress, .lookup_dest);
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // ******************************
    // bus and lookup helpers
    // ******************************
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // no wait limit here: the watchdog ends a hang
        do @(posedge clk_sys); while (pready !== 1'b1);
        rv = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic apply_ctrl(input logic [1:0] p, input logic sv);
        apb(1'b1, OFS_CTRL, {27'h0, sv, p, 2'b11});
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic look(input logic [7:0] i, input logic [NP:0] d);
        port_side_model_inst.send(i, d);
        @(posedge clk_sys);
        `CHK(fwd_valid, 1'b1)
        fm = fwd_mask;
    endtask
    // ******************************
    // scenarios
    // ******************************
    task automatic t_reset;
        `CHK(fwd_vid, 12'h001)
        look(8'h2, '1); `CHK(fm, 9'h100)
        look(8'h8, '1); `CHK(fm, 9'h1ff)
        look(8'h9, '1); `CHK(fm, 9'h000)
        apb(1'b1, OFS_VID, 32'h1); `CHK(er, 1'b0)
        apb(1'b0, OFS_VID, 32'h0); `CHK(rv[11:0], 12'h001)
        apb(1'b0, 8'h1c, 32'h0); `CHK(er, 1'b1)
        apb(1'b1, 8'h1c, 32'h0); `CHK(er, 1'b1)
    endtask
    task automatic t_presets;
        apb(1'b0, OFS_STATUS, 32'h0);
        s = rv[7:0];
        apply_ctrl(PRESET_ALL, 1'b0);
        apb(1'b0, OFS_STATUS, 32'h0); `CHK(rv[7:0], s + 8'h1)
        look(8'h3, '1); `CHK(fm, 9'h1ff)
        look(8'h8, 9'h0aa); `CHK(fm, 9'h0aa)
        apply_ctrl(PRESET_ISOLATE, 1'b0);
        look(8'h3, '1); `CHK(fm, 9'h100)
        look(8'h8, '1); `CHK(fm, 9'h1ff)
        look(8'h0, 9'h0fe); `CHK(fm, 9'h000)
    endtask
    task automatic t_edit;
        apb(1'b1, OFS_ROWSEL, 32'h2);
        apb(1'b1, OFS_EGRESS, 32'h108);
        apb(1'b0, OFS_EGRESS, 32'h0); `CHK(rv[8:0], 9'h108)
        apb(1'b0, OFS_ROWSEL, 32'h0); `CHK(rv[7:0], 8'h02)
        look(8'h2, '1); `CHK(fm, 9'h100)
        apply_ctrl(PRESET_NONE, 1'b0);
        look(8'h2, '1); `CHK(fm, 9'h108)
        look(8'h3, 9'h004); `CHK(fm, 9'h000)
        apb(1'b1, OFS_EGRESS, 32'h008);
        apply_ctrl(PRESET_NONE, 1'b0);
        look(8'h2, '1); `CHK(fm, 9'h008)
        apb(1'b1, OFS_INGRESS, 32'h1fb);
        apb(1'b0, OFS_INGRESS, 32'h0); `CHK(rv[8:0], 9'h1fb)
        apply_ctrl(PRESET_NONE, 1'b0);
        look(8'h2, '1); `CHK(fm, 9'h000)
    endtask
    task automatic t_save;
        apply_ctrl(PRESET_NONE, 1'b1);
        apb(1'b0, OFS_SAVED, 32'h0); `CHK(rv[8:0], 9'h008)
        srst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        look(8'h2, '1); `CHK(fm, 9'h100)
    endtask
    task automatic t_mode;
        apb(1'b1, OFS_CTRL, 32'h0); `CHK(er, 1'b0)
        repeat (3) @(posedge clk_sys);
        `CHK(pbv_active, 1'b0)
        apb(1'b0, OFS_CTRL, 32'h0); `CHK(rv[0], 1'b0)
        // mode off: a vlan id other than 1 may be offered
        apb(1'b1, OFS_VID, 32'h5);
        look(8'h2, 9'h0f0); `CHK(fm, 9'h0f0)
        apb(1'b1, OFS_CTRL, 32'h1);
        repeat (3) @(posedge clk_sys);
        `CHK(pbv_active, 1'b1)
        `CHK(fwd_vid, 12'h001)
        apb(1'b0, OFS_CTRL, 32'h0); `CHK(rv[0], 1'b1)
        apb(1'b0, OFS_VID, 32'h0); `CHK(rv[11:0], 12'h001)
        apb(1'b1, OFS_ROWSEL, 32'h9);
        apb(1'b1, OFS_EGRESS, 32'h1ff); `CHK(er, 1'b1)
        apb(1'b0, OFS_EGRESS, 32'h0); `CHK({er, rv[8:0]}, 10'h000)
    endtask
    task automatic close_out;
        if (n_fail == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        srst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        t_reset;
        t_presets;
        t_edit;
        t_save;
        t_mode;
        close_out;
    end
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        n_fail++;
        close_out;
    end
endmodule
`default_nettype wire
